// ### smp_regs.vh
// register offsets, field positions, reset values for the serial master burst port
// assumes inclusion by the design, checker and testbench files; definitions only
`ifndef SMP_REGS_VH
`define SMP_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SMP_OFS_CTRL      32'hfff8_6200
`define SMP_OFS_DIV       32'hfff8_6204
`define SMP_OFS_SEL       32'hfff8_6208
`define SMP_OFS_BUF0      32'hfff8_6210
`define SMP_OFS_BUF1      32'hfff8_6214
`define SMP_OFS_BUF2      32'hfff8_6218
`define SMP_OFS_BUF3      32'hfff8_621c

// ----------------------------------------
// reset values
// ----------------------------------------
`define SMP_RST_CTRL      32'h0000_0004
`define SMP_RST_DIV       32'h0000_0000
`define SMP_RST_SEL       32'h0000_0000
`define SMP_RST_BUF       32'h0000_0000

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SMP_CTRL_GO       0
`define SMP_CTRL_RXNEG    1
`define SMP_CTRL_TXNEG    2
`define SMP_CTRL_LEN_LO   3
`define SMP_CTRL_LEN_HI   7
`define SMP_CTRL_NUM_LO   8
`define SMP_CTRL_NUM_HI   9
`define SMP_CTRL_LSB      10
`define SMP_CTRL_GAP_LO   12
`define SMP_CTRL_GAP_HI   15
`define SMP_CTRL_DONE     16
`define SMP_CTRL_IE       17

// ----------------------------------------
// select register fields and timing
// ----------------------------------------
`define SMP_SEL_BITS_LO   0
`define SMP_SEL_BITS_HI   1
`define SMP_SEL_POL       2
`define SMP_SEL_AUTO      3
`define SMP_GAP_EXTRA     2

`endif

// ### smp_serial_master_port.v
// serial master burst port: register slave plus full duplex serial engine
// holds the control, divisor and select registers and four shared buffer words
// assumes a synchronous single-cycle register bus and one clock domain
// assumes the serial data input is already synchronous to the clock
`timescale 1ns/1ns
`include "smp_regs.vh"

// Functional notes
// RULE_01 - done flag set at transfer end, cleared by writing one
// RULE_02 - interrupt enable bit gates the interrupt request
// RULE_03 - pause of gap plus two serial clocks between words
// RULE_04 - lsb control picks bit order of transmit and receive
// RULE_05 - word count field selects one to four words
// RULE_06 - word length one to thirty-one bits, zero means thirty-two
// RULE_07 - data out changes on falling edge if transmit edge set
// RULE_08 - data in sampled on falling edge if receive edge set
// RULE_09 - writing go starts transfer; bit reads busy, self clears
// RULE_10 - all register writes ignored while a transfer runs
// RULE_11 - software programs everything before setting go last
// RULE_12 - serial clock equals clock over twice divider plus one
// RULE_13 - software should program divider of at least one
// RULE_14 - manual select follows the select bits directly
// RULE_15 - automatic select active only while each word shifts
// RULE_16 - select polarity bit sets active level
// RULE_17 - software addresses one peripheral, selects it before transfer
// RULE_18 - receive registers hold captured data of last transfer
// RULE_19 - receive and transmit words share the same flip-flops
// RULE_20 - words go out in ascending buffer order, same settings
// RULE_21 - shift out and in at once, full duplex
// RULE_22 - interrupt output high while flag and enable both set
// RULE_23 - each received word lands in its own transmit slot
module smp_serial_master_port #(
	parameter NUM_SEL = 2
) (
	input  wire                ref_clk_i,
	input  wire                rst_i,
	input  wire                bus_sel_i,
	input  wire                bus_wr_i,
	input  wire [31:0]         bus_addr_i,
	input  wire [31:0]         bus_wdata_i,
	output reg  [31:0]         bus_rdata_o,
	output reg                 irq_o,
	output reg                 serial_clock_out_o,
	output reg                 serial_data_out_o,
	input  wire                serial_data_in_i,
	output reg  [NUM_SEL-1:0]  peripheral_select_out_o
);

	// ----------------------------------------
	// state codes
	// ----------------------------------------
	localparam ST_IDLE  = 2'd0;
	localparam ST_SHIFT = 2'd1;
	localparam ST_GAP   = 2'd2;
	localparam ST_DONE  = 2'd3;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [31:0]        buf_word [0:3];
	reg                go_busy;
	reg                receive_edge_control;
	reg                transmit_edge_control;
	reg  [4:0]         word_length;
	reg  [1:0]         word_count;
	reg                lsb_first;
	reg  [3:0]         suspend_gap;
	reg                done_flag;
	reg                interrupt_enable_bit;
	reg  [15:0]        divisor;
	reg  [NUM_SEL-1:0] select_bits;
	reg                select_polarity;
	reg                automatic_select;
	reg  [1:0]         state;
	reg  [15:0]        div_cnt;
	reg  [5:0]         bit_cnt;
	reg  [1:0]         word_idx;
	reg  [5:0]         gap_cnt;
	reg                word_active;

	// ----------------------------------------
	// decoded strobes and bit positions
	// ----------------------------------------
	wire        wr_ok;
	wire        wr_ctrl;
	wire        wr_div;
	wire        wr_sel;
	wire        tick;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        last_bit;
	wire        last_word;
	wire        gap_over;
	wire [5:0]  nbits;
	wire [5:0]  nbits_m1;
	wire [4:0]  msb_pos;
	wire [4:0]  tx_pos;
	wire [4:0]  nx_pos;
	wire [5:0]  gap_end;
	wire [31:0] cur;
	reg         cap_en;
	reg  [4:0]  cap_pos;
	reg         next_sdo;
	reg         next_sdo_load;

	// writes are dropped for the whole transfer
	assign wr_ok     = bus_sel_i & bus_wr_i & ~go_busy; // RULE_10
	assign wr_ctrl   = wr_ok & (bus_addr_i == `SMP_OFS_CTRL);
	assign wr_div    = wr_ok & (bus_addr_i == `SMP_OFS_DIV);
	assign wr_sel    = wr_ok & (bus_addr_i == `SMP_OFS_SEL);
	// half-period tick of the serial clock
	assign tick      = (div_cnt == divisor); // RULE_12
	assign sclk_rise = (state == ST_SHIFT) & tick & ~serial_clock_out_o;
	assign sclk_fall = (state == ST_SHIFT) & tick & serial_clock_out_o;
	// length zero stands for a full 32-bit word
	assign nbits     = (word_length == 5'd0) ? 6'd32 : {1'b0, word_length}; // RULE_06
	assign nbits_m1  = nbits - 6'd1;
	assign msb_pos   = nbits_m1[4:0];
	assign last_bit  = (bit_cnt == nbits_m1);
	assign last_word = (word_idx == word_count); // RULE_05
	// gap of gap+2 periods is 2*gap+4 half periods, the last one spent in shift
	assign gap_end   = {1'b0, suspend_gap, 1'b0} + 6'd2; // RULE_03
	assign gap_over  = tick & (gap_cnt == gap_end);
	// one word index shared by shift-out and capture
	assign cur       = buf_word[word_idx];
	// bit position of the current and of the following bit
	assign tx_pos    = lsb_first ? bit_cnt[4:0] : msb_pos - bit_cnt[4:0]; // RULE_04
	assign nx_pos    = lsb_first ? bit_cnt[4:0] + 5'd1 : msb_pos - bit_cnt[4:0] - 5'd1; // RULE_04

	// ----------------------------------------
	// shift-out and capture selection
	// ----------------------------------------
	// first bit set up before the first rising edge, later bits on the chosen edge
	always @* begin
		next_sdo_load = 1'b0;
		next_sdo = serial_data_out_o;
		if (state == ST_SHIFT) begin
			if (bit_cnt == 6'd0 && !serial_clock_out_o && div_cnt == 16'h0000) begin
				next_sdo_load = 1'b1;
				next_sdo = cur[tx_pos]; // RULE_21
			end else if (sclk_rise && !transmit_edge_control && bit_cnt != 6'd0) begin
				next_sdo_load = 1'b1;
				next_sdo = cur[tx_pos]; // RULE_07
			end else if (sclk_fall && transmit_edge_control && !last_bit) begin
				next_sdo_load = 1'b1;
				next_sdo = cur[nx_pos]; // RULE_07
			end
		end
	end

	// receive sampling edge and the bit position it fills
	always @* begin
		cap_en = 1'b0;
		cap_pos = tx_pos;
		if (receive_edge_control)
			cap_en = sclk_fall; // RULE_08
		else
			cap_en = sclk_rise; // RULE_08
	end

	// ----------------------------------------
	// register writes and done flag
	// ----------------------------------------
	// control fields, taken only while idle
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			interrupt_enable_bit <= 1'b0;
			suspend_gap <= 4'h0;
			lsb_first <= 1'b0;
			word_count <= 2'b00;
			word_length <= 5'd0;
			transmit_edge_control <= 1'b1;
			receive_edge_control <= 1'b0;
		end else if (wr_ctrl) begin
			interrupt_enable_bit <= bus_wdata_i[`SMP_CTRL_IE]; // RULE_02
			suspend_gap <= bus_wdata_i[`SMP_CTRL_GAP_HI:`SMP_CTRL_GAP_LO];
			lsb_first <= bus_wdata_i[`SMP_CTRL_LSB];
			word_count <= bus_wdata_i[`SMP_CTRL_NUM_HI:`SMP_CTRL_NUM_LO];
			word_length <= bus_wdata_i[`SMP_CTRL_LEN_HI:`SMP_CTRL_LEN_LO];
			transmit_edge_control <= bus_wdata_i[`SMP_CTRL_TXNEG];
			receive_edge_control <= bus_wdata_i[`SMP_CTRL_RXNEG];
		end
	end

	// clock divisor and select control
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			divisor <= 16'h0000;
			select_bits <= {NUM_SEL{1'b0}};
			select_polarity <= 1'b0;
			automatic_select <= 1'b0;
		end else begin
			if (wr_div)
				divisor <= bus_wdata_i[15:0]; // RULE_12
			if (wr_sel) begin
				select_bits <= bus_wdata_i[NUM_SEL-1:0];
				select_polarity <= bus_wdata_i[`SMP_SEL_POL]; // RULE_16
				automatic_select <= bus_wdata_i[`SMP_SEL_AUTO]; // RULE_15
			end
		end
	end

	// completion flag: set wins over a same-cycle write-one clear
	always @(posedge ref_clk_i) begin
		if (rst_i)
			done_flag <= 1'b0;
		else if (state == ST_DONE)
			done_flag <= 1'b1; // RULE_01
		else if (wr_ctrl && bus_wdata_i[`SMP_CTRL_DONE])
			done_flag <= 1'b0; // RULE_01
	end

	// ----------------------------------------
	// transfer engine: divider, shift, gap
	// ----------------------------------------
	// state, counters and serial pins; data bits come from the selection above
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			go_busy <= 1'b0;
			div_cnt <= 16'h0000;
			bit_cnt <= 6'd0;
			word_idx <= 2'd0;
			gap_cnt <= 6'd0;
			word_active <= 1'b0;
			serial_clock_out_o <= 1'b0;
			serial_data_out_o <= 1'b0;
		end else begin
			if (next_sdo_load)
				serial_data_out_o <= next_sdo;
			case (state)
			ST_IDLE: begin
				// wait for a go write
				div_cnt <= 16'h0000;
				serial_clock_out_o <= 1'b0;
				if (wr_ctrl && bus_wdata_i[`SMP_CTRL_GO]) begin
					go_busy <= 1'b1; // RULE_09
					state <= ST_SHIFT;
					word_idx <= 2'd0; // RULE_20
					bit_cnt <= 6'd0;
					word_active <= 1'b1;
				end
			end
			ST_SHIFT: begin
				// divider counts half periods of the serial clock
				div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
				if (tick)
					serial_clock_out_o <= ~serial_clock_out_o; // RULE_12
				// falling edge closes a bit; the last one closes the word
				if (sclk_fall) begin
					if (last_bit) begin
						bit_cnt <= 6'd0;
						word_active <= 1'b0;
						gap_cnt <= 6'd0;
						state <= last_word ? ST_DONE : ST_GAP; // RULE_05
					end else begin
						bit_cnt <= bit_cnt + 6'd1;
					end
				end
			end
			ST_GAP: begin
				// clock held low between words, counted in half periods
				div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
				if (tick)
					gap_cnt <= gap_cnt + 6'd1;
				if (gap_over) begin
					state <= ST_SHIFT; // RULE_03
					word_idx <= word_idx + 2'd1; // RULE_20
					word_active <= 1'b1;
					div_cnt <= 16'h0000;
				end
			end
			ST_DONE: begin
				// one cycle to raise the flag and drop busy together
				go_busy <= 1'b0; // RULE_09
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// shared buffer words (transmit written, receive captured)
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_buf
			// capture cannot meet a write: writes are refused while busy
			always @(posedge ref_clk_i) begin
				if (rst_i)
					buf_word[gi] <= `SMP_RST_BUF;
				else if (wr_ok && bus_addr_i == `SMP_OFS_BUF0 + gi * 4)
					buf_word[gi] <= bus_wdata_i; // RULE_19
				else if (cap_en && word_idx == gi)
					buf_word[gi][cap_pos] <= serial_data_in_i; // RULE_08 RULE_23
			end
		end
	endgenerate

	// ----------------------------------------
	// select, interrupt, read data outputs
	// ----------------------------------------
	reg  [31:0]        next_rdata;
	reg  [NUM_SEL-1:0] next_sel;

	// read data for the address presented this cycle
	always @* begin
		next_rdata = 32'h0000_0000;
		case (bus_addr_i)
		`SMP_OFS_CTRL: next_rdata = {14'd0, interrupt_enable_bit, done_flag, suspend_gap, 1'b0,
			lsb_first, word_count, word_length, transmit_edge_control, receive_edge_control, go_busy};
		`SMP_OFS_DIV:  next_rdata = {16'd0, divisor};
		`SMP_OFS_SEL:  next_rdata = {{(30-NUM_SEL){1'b0}}, automatic_select, select_polarity, select_bits};
		`SMP_OFS_BUF0: next_rdata = buf_word[0];
		`SMP_OFS_BUF1: next_rdata = buf_word[1];
		`SMP_OFS_BUF2: next_rdata = buf_word[2];
		`SMP_OFS_BUF3: next_rdata = buf_word[3];
		default:       next_rdata = 32'h0000_0000;
		endcase
	end

	// auto mode drives the chosen line only while a word shifts
	always @* begin
		if (automatic_select)
			next_sel = word_active ? select_bits : {NUM_SEL{1'b0}}; // RULE_15
		else
			next_sel = select_bits; // RULE_14
	end

	// outputs straight from flip-flops; reset leaves active-low selects inactive
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			peripheral_select_out_o <= {NUM_SEL{1'b1}};
			irq_o <= 1'b0;
			bus_rdata_o <= 32'h0000_0000;
		end else begin
			peripheral_select_out_o <= next_sel ^ {NUM_SEL{~select_polarity}}; // RULE_16
			irq_o <= done_flag & interrupt_enable_bit; // RULE_22
			bus_rdata_o <= next_rdata; // RULE_18
		end
	end

endmodule

// ### smp_port_props.sv
// checker: readback and output relations of the serial master port
// assumes only the top module's ports; bound after the module
`timescale 1ns/1ns
`include "smp_regs.vh"
module smp_port_props #(
	parameter NUM_SEL = 2
) (
	input wire               ref_clk_i,
	input wire               rst_i,
	input wire               bus_sel_i,
	input wire               bus_wr_i,
	input wire [31:0]        bus_addr_i,
	input wire [31:0]        bus_wdata_i,
	input wire [31:0]        bus_rdata_o,
	input wire               irq_o,
	input wire               serial_clock_out_o,
	input wire               serial_data_out_o,
	input wire               serial_data_in_i,
	input wire [NUM_SEL-1:0] peripheral_select_out_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_irq_follows_flag: assert property (
		bus_addr_i == `SMP_OFS_CTRL |=> irq_o == (bus_rdata_o[16] && bus_rdata_o[17])) else $error("irq mismatch");
	a_irq_fall_write: assert property (
		$fell(irq_o) |-> $past(bus_sel_i && bus_wr_i && bus_addr_i == `SMP_OFS_CTRL, 2)) else $error("irq fell alone");
	a_idle_clock_low: assert property (
		bus_addr_i == `SMP_OFS_CTRL ##1 !bus_rdata_o[0] |-> !serial_clock_out_o) else $error("clock moved idle");
	a_manual_select: assert property (
		bus_addr_i == `SMP_OFS_SEL ##1 !bus_rdata_o[3] |-> peripheral_select_out_o ==
		({NUM_SEL{bus_rdata_o[2]}} ~^ bus_rdata_o[NUM_SEL-1:0])) else $error("manual select wrong");
	a_divider_width: assert property (
		bus_addr_i == `SMP_OFS_DIV |=> bus_rdata_o[31:16] == 16'h0000) else $error("divider too wide");
	a_select_fields: assert property (
		bus_addr_i == `SMP_OFS_SEL |=> bus_rdata_o[31:4] == 28'h000_0000) else $error("select reserved set");
	a_ctrl_fields: assert property (
		bus_addr_i == `SMP_OFS_CTRL |=> !bus_rdata_o[11] && bus_rdata_o[31:18] == 14'h0000) else $error("ctrl reserved");
	a_gap_reads_zero: assert property (
		bus_addr_i == 32'hfff8_620c |=> bus_rdata_o == 32'h0000_0000) else $error("gap offset nonzero");
endmodule

bind smp_serial_master_port smp_port_props #(.NUM_SEL(NUM_SEL)) i_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.bus_sel_i(bus_sel_i), .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
	.bus_rdata_o(bus_rdata_o), .irq_o(irq_o), .serial_clock_out_o(serial_clock_out_o),
	.serial_data_out_o(serial_data_out_o), .serial_data_in_i(serial_data_in_i),
	.peripheral_select_out_o(peripheral_select_out_o));

// ### smp_peer_model.sv
// peripheral model: shifts a reply word out, captures the port's data
// assumes reply changes on falling and capture on rising serial clock
`timescale 1ns/1ns
module smp_peer_model (
	input  wire serial_clock_i,
	input  wire frame_i,
	input  wire serial_data_i,
	output wire serial_data_o
);
	reg [31:0] tx;
	reg [31:0] got;
	// capture on the rising edge
	always @(posedge serial_clock_i) begin
		got <= {got[30:0], serial_data_i};
	end
	// next reply bit on the falling edge
	always @(negedge serial_clock_i) begin
		tx <= {tx[30:0], tx[31]};
	end
	// unselected line shows the inverse of the last bit
	assign serial_data_o = frame_i ? tx[31] : ~tx[31];
endmodule

// ### serial_master_burst_port_tb.sv
// testbench: register tasks and transfer scenarios for the serial master port
// assumes the peripheral model and the bound checker
`timescale 1ns/1ns
`include "smp_regs.vh"
module serial_master_burst_port_tb;
	reg         ref_clk_i;
	reg         rst_i;
	reg         bus_sel_i;
	reg         bus_wr_i;
	reg  [31:0] bus_addr_i;
	reg  [31:0] bus_wdata_i;
	wire [31:0] bus_rdata_o;
	wire        irq_o;
	wire        sclk;
	wire        sdo;
	wire        sdi;
	wire [1:0]  sel_out;
	reg  [31:0] rv;
	integer     errors;
	integer     tests_run;

	smp_serial_master_port #(.NUM_SEL(2)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_sel_i(bus_sel_i),
		.bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
		.irq_o(irq_o), .serial_clock_out_o(sclk), .serial_data_out_o(sdo), .serial_data_in_i(sdi),
		.peripheral_select_out_o(sel_out));
	smp_peer_model i_peer (.serial_clock_i(sclk), .frame_i(sel_out != 2'b11), .serial_data_i(sdo),
		.serial_data_o(sdi));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("Error at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task acc(input w, input [31:0] a, input [31:0] d);
		begin
			@(posedge ref_clk_i) #1;
			{bus_sel_i, bus_wr_i, bus_addr_i, bus_wdata_i} = {1'b1, w, a, d};
			@(posedge ref_clk_i) #1;
			bus_sel_i = 1'b0;
			rv = bus_rdata_o;
		end
	endtask
	task rdchk(input [31:0] a, input [31:0] m, input [31:0] exp);
		begin
			acc(1'b0, a, 32'h0000_0000);
			chk(rv & m, exp);
		end
	endtask
	task wait_idle;
		integer n;
		begin
			rv = 32'h0000_0001;
			for (n = 0; n < 400 && rv[0] !== 1'b0; n = n + 1)
				acc(1'b0, `SMP_OFS_CTRL, 32'h0000_0000);
		end
	endtask
	task print_verdict;
		begin
			$display("Comparisons %0d, mismatches %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0) begin
				$display("Test passed");
			end else begin
				$display("Test failed");
			end
			$finish;
		end
	endtask

	// clock and watchdog
	always #5 ref_clk_i = ~ref_clk_i;
	initial begin
		#20000;
		errors = errors + 1;
		print_verdict;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{ref_clk_i, rst_i, bus_sel_i, bus_wr_i, bus_addr_i, bus_wdata_i} = {4'b0100, 64'h0};
		errors = 0;
		tests_run = 0;
		i_peer.tx = 32'h3cc3_0000;
		repeat (10) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		rdchk(`SMP_OFS_CTRL, 32'hffff_ffff, `SMP_RST_CTRL);
		rdchk(`SMP_OFS_SEL, 32'hffff_ffff, `SMP_RST_SEL);
		rdchk(32'hfff8_620c, 32'hffff_ffff, 32'h0000_0000);
		// two auto-select words, msb first, irq enabled
		acc(1'b1, `SMP_OFS_DIV, 32'h0000_0001);
		acc(1'b1, `SMP_OFS_SEL, 32'h0000_0009);
		acc(1'b1, `SMP_OFS_BUF0, 32'h0000_00a5);
		acc(1'b1, `SMP_OFS_BUF1, 32'h0000_005a);
		acc(1'b1, `SMP_OFS_CTRL, 32'h0002_0145);
		acc(1'b1, `SMP_OFS_DIV, 32'h0000_0005);
		rdchk(`SMP_OFS_CTRL, 32'h0000_0001, 32'h0000_0001);
		chk({30'h0, sel_out}, 32'h0000_0002);
		wait_idle;
		chk({30'h0, sel_out}, 32'h0000_0003);
		rdchk(`SMP_OFS_DIV, 32'hffff_ffff, 32'h0000_0001);
		rdchk(`SMP_OFS_BUF0, 32'h0000_00ff, 32'h0000_003c);
		rdchk(`SMP_OFS_BUF1, 32'h0000_00ff, 32'h0000_00c3);
		chk(i_peer.got & 32'h0000_ffff, 32'h0000_a55a);
		chk({31'h0, irq_o}, 32'h0000_0001);
		rdchk(`SMP_OFS_CTRL, 32'hffff_ffff, 32'h0003_0144);
		acc(1'b1, `SMP_OFS_CTRL, 32'h0003_0044);
		rdchk(`SMP_OFS_CTRL, 32'hffff_ffff, 32'h0002_0044);
		chk({31'h0, irq_o}, 32'h0000_0000);
		// one manual-select word of 32 bits, lsb first, irq off
		i_peer.tx = 32'hc000_0000;
		acc(1'b1, `SMP_OFS_SEL, 32'h0000_0001);
		@(posedge ref_clk_i) #1;
		chk({30'h0, sel_out}, 32'h0000_0002);
		acc(1'b1, `SMP_OFS_BUF0, 32'h1234_5678);
		acc(1'b1, `SMP_OFS_CTRL, 32'h0000_0405);
		wait_idle;
		chk(i_peer.got, 32'h1e6a_2c48);
		rdchk(`SMP_OFS_BUF0, 32'hffff_ffff, 32'h0000_0003);
		rdchk(`SMP_OFS_CTRL, 32'h0001_0001, 32'h0001_0000);
		chk({31'h0, irq_o}, 32'h0000_0000);
		print_verdict;
	end
endmodule
